/* File: ubch_core.sv */
// Summary of operation
// [R1] Query answers OK, the state code and an optional detail field.
// [R2] Code 0 when idle, code 3 while download or verification runs.
// [R3] Code 1 for a proposed module update, detail is its version string.
// [R4] Code 2 for a proposed host update, detail is operator metadata.
// [R5] Code 4 when verified module image is ready to reboot; event raised.
// [R6] Code 5 when verified host image readable; detail is size; event raised.
// [R7] Accept lets a pending proposal download; reply OK and start it.
// [R8] Accept with nothing pending replies invalid update error.
// [R9] Read pointer starts at 0; host gives read count in decimal.
// [R10] Read reply: OK, hex count, hex bytes, four-digit hex checksum.
// [R11] Pointer advances by returned count; fewer or zero at end.
// [R12] Zero count omits data and checksum from the reply.
// [R13] Requests above the maximum are clipped to the maximum.
// [R14] Checksum is 16-bit sum of returned bytes, modulo 2^16.
// [R15] Read, seek, apply with empty or busy buffer give image unavailable.
// [R16] Seek moves pointer to given address or 0; echo new address.
// [R17] Seek beyond content size gives bad address, pointer unchanged.
// [R18] Apply on verified module image replies OK, boots, empties buffer.
// [R19] Apply rejects bad integrity/version or failed signature with errors.
// [R20] After apply reboot: flush events, post boot complete, reset state.
// [R21] Close releases buffer, clears flag, OK, reports success upstream.
// [R22] Flush releases buffer at once, stops work, OK, reports failure.
// [R23] Further host payload deliveries refused while one is staged.
// [R24] Update request queues an event and raises the event pin.
// [R25] Rejected read or seek leaves pointer unchanged.
// [R26] State code is one register updated on every transition.
`timescale 1ns/100ps
module ubch_core #(
  parameter int          MAX_READ_BYTES = 1024,
  parameter int          BOOT_CYCLES    = ubch_pkg::BOOT_CYC
) (
  // Clock and reset
  input  wire logic                   clk_sys_in,
  input  wire logic                   resetn_in,
  // Parsed command in
  input  wire ubch_pkg::ubch_req_t    req_in,
  output logic                        req_ready_out,
  // Reply header out
  output ubch_pkg::ubch_rsp_pkt_t     rsp_out,
  // Read data stream out, one byte a beat
  output logic                        rd_valid_out,
  output logic [7:0]                  rd_data_out,
  output logic                        rd_last_out,
  output logic [15:0]                 rd_csum_out,
  input  wire logic                   rd_ready_in,
  // Staged buffer memory port, combinational read
  output logic [23:0]                 buf_addr_out,
  input  wire logic [7:0]             buf_data_in,
  // Upstream job side
  input  wire logic                   prop_mod_in,
  input  wire logic                   prop_host_in,
  output logic                        prop_nack_out,
  input  wire logic                   dl_done_in,
  input  wire logic                   sig_ok_in,
  input  wire logic                   img_ok_in,
  input  wire logic [23:0]            img_size_in,
  output logic                        dl_start_out,
  output logic                        report_ok_out,
  output logic                        report_fail_out,
  input  wire logic                   report_err_in,
  output logic                        boot_start_out,
  // Event side
  input  wire logic                   ev_pop_in,
  output logic [2:0]                  ev_code_out,
  output logic                        ev_pin_out,
  // Detail selector for the formatter
  output logic                        detail_is_version_out,
  output logic                        detail_is_meta_out
);

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_READ = 2'b01,
    PH_BOOT = 2'b11
  } ubch_phase_t;

  typedef struct packed {
    ubch_phase_t             phase;
    logic [2:0]              state;
    logic                    is_module;
    logic [23:0]             size;
    logic [23:0]             ptr;
    logic [23:0]             remain;
    logic [15:0]             csum;
    logic [31:0]             boot_cnt;
    ubch_pkg::ubch_rsp_pkt_t rsp;
    logic                    dl_start;
    logic                    rep_ok;
    logic                    rep_fail;
    logic                    boot;
  } ubch_core_state_t;

  ubch_core_state_t s_reg;
  ubch_core_state_t s_next;

  logic       ev_push;
  logic [2:0] ev_code;
  logic       ev_flush;

  // Ready image buffer check, shared by read and seek; apply checks ST_MOD_READY alone
  function automatic logic img_ready(input logic [2:0] st);
    img_ready = (st == ubch_pkg::ST_MOD_READY) || (st == ubch_pkg::ST_HOST_RDY);
  endfunction

  // Reply builder
  function automatic ubch_pkg::ubch_rsp_pkt_t mk_rsp(input ubch_pkg::ubch_rsp_t st,
    input logic [2:0] code, input logic [23:0] val, input logic det);
    mk_rsp = '{valid: 1'b1, status: st, code: code, value: val, has_detail: det};
  endfunction

  // Status-only reply for refusals and plain OK
  function automatic ubch_pkg::ubch_rsp_pkt_t rsp_st(input ubch_pkg::ubch_rsp_t st);
    rsp_st = mk_rsp(st, 3'h0, 24'h000000, 1'b0);
  endfunction

  logic [23:0] avail;
  logic [23:0] want;
  logic [23:0] grant;

  // Clip request to maximum and to remaining content
  always_comb
  begin
    avail = s_reg.size - s_reg.ptr;
    want  = (req_in.arg > 24'(MAX_READ_BYTES)) ? 24'(MAX_READ_BYTES) : req_in.arg; // [R13]
    grant = (want > avail) ? avail : want; // [R11]
  end

  // Main next-state logic
  always_comb
  begin
    s_next          = s_reg;
    s_next.rsp      = '0;
    s_next.dl_start = 1'b0;
    s_next.rep_ok   = 1'b0;
    s_next.rep_fail = 1'b0;
    s_next.boot     = 1'b0;
    ev_push         = 1'b0;
    ev_code         = 3'h0;
    ev_flush        = 1'b0;

    // Upstream progress moves the single state register
    if (s_reg.state == ubch_pkg::ST_IDLE && s_reg.phase == PH_IDLE)
    begin
      if (prop_mod_in || prop_host_in)
      begin
        s_next.state     = prop_mod_in ? ubch_pkg::ST_MOD_PROP : ubch_pkg::ST_HOST_PROP; // [R3] [R4] [R26]
        s_next.is_module = prop_mod_in;
        ev_push          = 1'b1; // [R24]
        ev_code          = ubch_pkg::UBCH_EV_REQUEST;
      end
    end
    else if (s_reg.state == ubch_pkg::ST_BUSY && dl_done_in)
    begin
      s_next.size = img_size_in;
      s_next.ptr  = ubch_pkg::PTR_RESET; // [R9]
      ev_push     = 1'b1;
      if (s_reg.is_module)
      begin
        s_next.state = ubch_pkg::ST_MOD_READY; // [R5]
        ev_code      = ubch_pkg::UBCH_EV_MOD_READY;
      end
      else
      begin
        s_next.state = ubch_pkg::ST_HOST_RDY; // [R6]
        ev_code      = ubch_pkg::UBCH_EV_HOST_READY;
      end
    end

    if (report_err_in)
    begin
      ev_push = 1'b1; // [R21] [R22]
      ev_code = ubch_pkg::UBCH_EV_LINK_FAIL;
    end

    case (s_reg.phase)
      PH_IDLE:
      begin
        if (req_in.valid)
        begin
          case (req_in.op)
            ubch_pkg::UBCH_CMD_QUERY:
            begin
              s_next.rsp = mk_rsp(ubch_pkg::UBCH_RSP_OK, s_reg.state, s_reg.size,
                                  s_reg.state inside {ubch_pkg::ST_MOD_PROP,
                                                      ubch_pkg::ST_HOST_PROP,
                                                      ubch_pkg::ST_HOST_RDY}); // [R1] [R2]
            end
            ubch_pkg::UBCH_CMD_ACCEPT:
            begin
              if (s_reg.state == ubch_pkg::ST_MOD_PROP || s_reg.state == ubch_pkg::ST_HOST_PROP)
              begin
                s_next.state    = ubch_pkg::ST_BUSY; // [R7]
                s_next.dl_start = 1'b1;
                s_next.rsp      = rsp_st(ubch_pkg::UBCH_RSP_OK);
              end
              else
              begin
                s_next.rsp = rsp_st(ubch_pkg::UBCH_RSP_INVALID); // [R8]
              end
            end
            ubch_pkg::UBCH_CMD_READ:
            begin
              if (!img_ready(s_reg.state))
              begin
                s_next.rsp = rsp_st(ubch_pkg::UBCH_RSP_UNAVAILABLE); // [R15] [R25]
              end
              else
              begin
                // Zero grant replies with the count alone
                s_next.rsp    = mk_rsp(ubch_pkg::UBCH_RSP_OK, 3'h0, grant, 1'b0); // [R10] [R12]
                s_next.remain = grant;
                s_next.csum   = ubch_pkg::CSUM_RESET;
                if (grant != 24'h000000)
                begin
                  s_next.phase = PH_READ;
                end
              end
            end
            ubch_pkg::UBCH_CMD_SEEK:
            begin
              if (!img_ready(s_reg.state))
              begin
                s_next.rsp = rsp_st(ubch_pkg::UBCH_RSP_UNAVAILABLE); // [R15]
              end
              else if (req_in.arg_given && req_in.arg > s_reg.size)
              begin
                s_next.rsp = rsp_st(ubch_pkg::UBCH_RSP_BAD_ADDR); // [R17] [R25]
              end
              else
              begin
                s_next.ptr = req_in.arg_given ? req_in.arg : ubch_pkg::PTR_RESET; // [R16]
                s_next.rsp = mk_rsp(ubch_pkg::UBCH_RSP_OK, 3'h0, s_next.ptr, 1'b0);
              end
            end
            ubch_pkg::UBCH_CMD_APPLY:
            begin
              if (s_reg.state != ubch_pkg::ST_MOD_READY)
              begin
                s_next.rsp = rsp_st(ubch_pkg::UBCH_RSP_UNAVAILABLE); // [R15]
              end
              else if (!sig_ok_in)
              begin
                s_next.rsp = rsp_st(ubch_pkg::UBCH_RSP_BAD_SIG); // [R19]
              end
              else if (!img_ok_in)
              begin
                s_next.rsp = rsp_st(ubch_pkg::UBCH_RSP_INVALID); // [R19]
              end
              else
              begin
                s_next.rsp      = rsp_st(ubch_pkg::UBCH_RSP_OK); // [R18]
                s_next.boot     = 1'b1;
                s_next.boot_cnt = 32'(BOOT_CYCLES);
                s_next.phase    = PH_BOOT;
              end
            end
            ubch_pkg::UBCH_CMD_CLOSE, ubch_pkg::UBCH_CMD_FLUSH:
            begin
              s_next.state    = ubch_pkg::ST_IDLE; // [R21] [R22]
              s_next.size     = 24'h000000;
              s_next.ptr      = ubch_pkg::PTR_RESET;
              s_next.rep_ok   = (req_in.op == ubch_pkg::UBCH_CMD_CLOSE);
              s_next.rep_fail = (req_in.op == ubch_pkg::UBCH_CMD_FLUSH);
              s_next.rsp      = rsp_st(ubch_pkg::UBCH_RSP_OK);
            end
            default:
            begin
              s_next.rsp = rsp_st(ubch_pkg::UBCH_RSP_INVALID);
            end
          endcase
        end
      end
      PH_READ:
      begin
        // One byte per accepted beat; checksum wraps naturally at 16 bits
        if (rd_ready_in)
        begin
          s_next.csum   = s_reg.csum + {8'h00, buf_data_in}; // [R14]
          s_next.ptr    = s_reg.ptr + 24'h000001; // [R11]
          s_next.remain = s_reg.remain - 24'h000001;
          if (s_reg.remain == 24'h000001)
          begin
            s_next.phase = PH_IDLE;
          end
        end
      end
      PH_BOOT:
      begin
        // Boot modelled as a fixed delay, then reset-like state
        if (s_reg.boot_cnt <= 32'h00000001)
        begin
          s_next.phase     = PH_IDLE;
          s_next.state     = ubch_pkg::ST_IDLE; // [R18] [R20]
          s_next.size      = 24'h000000;
          s_next.ptr       = ubch_pkg::PTR_RESET;
          s_next.is_module = 1'b0;
          ev_flush         = 1'b1; // [R20]
          ev_push          = 1'b1;
          ev_code          = ubch_pkg::UBCH_EV_BOOT_DONE;
        end
        else
        begin
          s_next.boot_cnt = s_reg.boot_cnt - 32'h00000001;
        end
      end
      default:
      begin
        s_next.phase = PH_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Event queue; flush happens before the boot-complete push
  ubch_event_queue #(
    .DEPTH (ubch_pkg::EVQ_DEPTH)
  ) u_evq (
    .clk_sys_in   (clk_sys_in),
    .resetn_in    (resetn_in),
    .push_in      (ev_push),
    .push_code_in (ev_code),
    .flush_in     (ev_flush),
    .pop_in       (ev_pop_in),
    .pend_out     (ev_pin_out), // [R24]
    .code_out     (ev_code_out)
  );

  // Outputs
  assign req_ready_out = (s_reg.phase == PH_IDLE);
  assign rsp_out = s_reg.rsp;
  assign rd_valid_out = (s_reg.phase == PH_READ);
  assign rd_data_out = buf_data_in;
  assign rd_last_out = (s_reg.phase == PH_READ) && (s_reg.remain == 24'h000001);
  assign rd_csum_out = s_reg.csum;
  assign buf_addr_out = s_reg.ptr;
  assign prop_nack_out = (s_reg.state != ubch_pkg::ST_IDLE) && prop_host_in; // [R23]
  assign dl_start_out = s_reg.dl_start;
  assign report_ok_out = s_reg.rep_ok;
  assign report_fail_out = s_reg.rep_fail;
  assign boot_start_out = s_reg.boot;
  assign detail_is_version_out = (s_reg.state == ubch_pkg::ST_MOD_PROP);
  assign detail_is_meta_out = (s_reg.state == ubch_pkg::ST_HOST_PROP);
endmodule

/* File: ubch_pkg.sv */
package ubch_pkg;

  // Update state codes
  localparam logic [2:0] ST_IDLE      = 3'h0;
  localparam logic [2:0] ST_MOD_PROP  = 3'h1;
  localparam logic [2:0] ST_HOST_PROP = 3'h2;
  localparam logic [2:0] ST_BUSY      = 3'h3;
  localparam logic [2:0] ST_MOD_READY = 3'h4;
  localparam logic [2:0] ST_HOST_RDY  = 3'h5;

  // Command opcodes
  typedef enum logic [2:0] {
    UBCH_CMD_QUERY  = 3'h0,
    UBCH_CMD_ACCEPT = 3'h1,
    UBCH_CMD_READ   = 3'h2,
    UBCH_CMD_SEEK   = 3'h3,
    UBCH_CMD_APPLY  = 3'h4,
    UBCH_CMD_CLOSE  = 3'h5,
    UBCH_CMD_FLUSH  = 3'h6
  } ubch_cmd_t;

  // Reply status
  typedef enum logic [2:0] {
    UBCH_RSP_OK          = 3'h0,
    UBCH_RSP_UNAVAILABLE = 3'h1,
    UBCH_RSP_BAD_ADDR    = 3'h2,
    UBCH_RSP_INVALID     = 3'h3,
    UBCH_RSP_BAD_SIG     = 3'h4
  } ubch_rsp_t;

  // Event codes
  typedef enum logic [2:0] {
    UBCH_EV_REQUEST    = 3'h1,
    UBCH_EV_MOD_READY  = 3'h2,
    UBCH_EV_HOST_READY = 3'h3,
    UBCH_EV_BOOT_DONE  = 3'h4,
    UBCH_EV_LINK_FAIL  = 3'h5
  } ubch_ev_t;

  localparam logic [23:0] PTR_RESET  = 24'h000000;
  localparam logic [23:0] MAX_READ   = 24'h000400;
  localparam logic [15:0] CSUM_RESET = 16'h0000;
  localparam int          EVQ_DEPTH  = 4;
  localparam int          BOOT_NS    = 1000;
  localparam int          CLK_NS     = 8;
  localparam int          BOOT_CYC   = (BOOT_NS + CLK_NS - 1) / CLK_NS;

  // Command from the parser
  typedef struct packed {
    logic        valid;
    ubch_cmd_t   op;
    logic [23:0] arg;
    logic        arg_given;
  } ubch_req_t;

  // Reply header to the formatter
  typedef struct packed {
    logic        valid;
    ubch_rsp_t   status;
    logic [2:0]  code;
    logic [23:0] value;
    logic        has_detail;
  } ubch_rsp_pkt_t;

endpackage

/* File: ubch_event_queue.sv */
`timescale 1ns/100ps
module ubch_event_queue #(
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  // Push and flush
  input  wire logic        push_in,
  input  wire logic [2:0]  push_code_in,
  input  wire logic        flush_in,
  // Pop side
  input  wire logic        pop_in,
  output logic             pend_out,
  output logic [2:0]       code_out
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][2:0] mem;
    logic [PW:0]           cnt;
  } ubch_evq_state_t;

  ubch_evq_state_t s_reg;
  ubch_evq_state_t s_next;

  // Shift queue; full drops the newest, and a push survives a flush in the same cycle
  always_comb
  begin
    s_next = s_reg;
    if (flush_in)
    begin
      s_next.cnt = '0;
    end
    else if (pop_in && s_reg.cnt != '0)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        s_next.mem[i] = s_reg.mem[i+1];
      end
      s_next.cnt = s_reg.cnt - 1'b1;
    end
    if (push_in && s_next.cnt != (PW+1)'(DEPTH))
    begin
      s_next.mem[s_next.cnt[PW-1:0]] = push_code_in;
      s_next.cnt = s_next.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign pend_out = (s_reg.cnt != '0);
  assign code_out = s_reg.mem[0];
endmodule

/* File: ubch_core_properties.sv */
`timescale 1ns/100ps
module ubch_core_properties #(
  parameter int MAX_READ_BYTES = 1024
) (
  // Clock and reset
  input  wire logic                    clk_sys_in,
  input  wire logic                    resetn_in,
  // Command and reply
  input  wire ubch_pkg::ubch_req_t     req_in,
  input  wire logic                    req_ready_out,
  input  wire ubch_pkg::ubch_rsp_pkt_t rsp_out,
  // Read stream and pointer
  input  wire logic                    rd_valid_out,
  input  wire logic [7:0]              rd_data_out,
  input  wire logic                    rd_last_out,
  input  wire logic [15:0]             rd_csum_out,
  input  wire logic                    rd_ready_in,
  input  wire logic [23:0]             buf_addr_out,
  // Upstream and events
  input  wire logic                    report_ok_out,
  input  wire logic                    report_fail_out,
  input  wire logic                    boot_start_out,
  input  wire logic [2:0]              ev_code_out,
  input  wire logic                    ev_pin_out
);
  // Bound must cover the default boot count, not only the short one
  localparam int BOOT_LIM = 300;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  // Command steps: taken, then answered
  sequence s_take(ubch_pkg::ubch_cmd_t op);
    req_in.valid && req_ready_out && req_in.op == op;
  endsequence
  sequence s_read_done;
    s_take(ubch_pkg::UBCH_CMD_READ) ##1 rsp_out.valid;
  endsequence
  sequence s_seek_done;
    s_take(ubch_pkg::UBCH_CMD_SEEK) ##1 rsp_out.valid;
  endsequence

  // Reply timing and content
  chk_reply_next: assert property (req_in.valid && req_ready_out |=> rsp_out.valid)
    else $error("command not answered on next cycle");
  chk_query_ok: assert property (s_take(ubch_pkg::UBCH_CMD_QUERY) |=>
    rsp_out.status == ubch_pkg::UBCH_RSP_OK && rsp_out.code <= 3'h5)
    else $error("query reply malformed");
  chk_read_cap: assert property (s_read_done |-> rsp_out.value <= 24'(MAX_READ_BYTES)
    && rsp_out.value <= $past(req_in.arg)) else $error("read count above limit");
  chk_zero_quiet: assert property (s_read_done ##0 (rsp_out.value == 24'h0)
    |-> !rd_valid_out) else $error("stream after zero count");
  // Stream beats move the pointer and feed the checksum
  chk_beat_step: assert property (rd_valid_out && rd_ready_in |=>
    buf_addr_out == $past(buf_addr_out) + 24'h1) else $error("pointer not advanced");
  chk_stall_hold: assert property (rd_valid_out && !rd_ready_in |=>
    rd_valid_out && $stable(buf_addr_out)) else $error("stream moved while stalled");
  chk_csum_add: assert property (rd_valid_out && rd_ready_in |=>
    rd_csum_out == $past(rd_csum_out) + {8'h00, $past(rd_data_out)})
    else $error("checksum not summed");
  // Seek outcome
  chk_seek_echo: assert property (s_seek_done ##0 (rsp_out.status == ubch_pkg::UBCH_RSP_OK)
    |-> buf_addr_out == rsp_out.value) else $error("seek echo differs");
  chk_seek_keep: assert property (s_seek_done ##0 (rsp_out.status != ubch_pkg::UBCH_RSP_OK)
    |-> $stable(buf_addr_out)) else $error("refused seek moved pointer");
  // Upstream reports and boot
  chk_close_report: assert property (s_take(ubch_pkg::UBCH_CMD_CLOSE) |-> ##[1:2] report_ok_out)
    else $error("close not reported");
  chk_flush_report: assert property (s_take(ubch_pkg::UBCH_CMD_FLUSH) |-> ##[1:2] report_fail_out)
    else $error("flush not reported");
  chk_boot_event: assert property (boot_start_out |-> ##[1:BOOT_LIM]
    (ev_pin_out && ev_code_out == ubch_pkg::UBCH_EV_BOOT_DONE)) else $error("no boot event");
endmodule

bind ubch_core ubch_core_properties #(.MAX_READ_BYTES(MAX_READ_BYTES)) u_chk (.*);

/* File: ubch_store_model.sv */
`timescale 1ns/100ps
module ubch_store_model (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  // Staged store port
  input  wire logic [23:0] addr_in,
  output logic [7:0]       data_out,
  // Byte sink handshake
  output logic             ready_out
);
  logic [1:0] stall_reg;
  // Byte is a fixed function of its address so the bench can predict it
  assign data_out = addr_in[7:0] ^ 8'ha5;
  // Drop ready one cycle in three, so every long stream meets a stall
  always_ff @(posedge clk_sys_in or negedge resetn_in)
    if (!resetn_in)
    begin
      stall_reg <= 2'h0;
      ready_out <= 1'b0;
    end
    else
    begin
      stall_reg <= (stall_reg == 2'h2) ? 2'h0 : stall_reg + 2'h1;
      ready_out <= (stall_reg != 2'h2);
    end
endmodule

/* File: test_update_buffer_command_handler.sv */
`timescale 1ns/100ps
module test_update_buffer_command_handler;
  // Short read limit keeps the chunk cases small
  localparam int          MAXR = 8;
  localparam logic [23:0] SIZE = 24'h000010;
  ubch_pkg::ubch_req_t     req_in;
  ubch_pkg::ubch_rsp_pkt_t rsp_out, rsp_q;
  logic                    clk_sys_in, resetn_in, req_ready_out, rd_valid_out, rd_last_out;
  logic                    rd_ready_in, prop_mod_in, prop_host_in, prop_nack_out, dl_done_in;
  logic                    sig_ok_in, img_ok_in, dl_start_out, report_ok_out, report_fail_out;
  logic                    report_err_in, boot_start_out, ev_pop_in, ev_pin_out;
  logic                    detail_is_version_out, detail_is_meta_out;
  logic [7:0]              rd_data_out, buf_data_in;
  logic [15:0]             rd_csum_out;
  logic [23:0]             buf_addr_out, img_size_in, ptr;
  logic [2:0]              ev_code_out;
  int                      num_errors = 0, total_checks = 0, n_dl = 0, n_ok = 0, n_fail = 0;

  ubch_core #(.MAX_READ_BYTES(MAXR), .BOOT_CYCLES(2)) u_dut (.*);
  ubch_store_model u_store (
    .clk_sys_in, .resetn_in, .addr_in(buf_addr_out), .data_out(buf_data_in),
    .ready_out(rd_ready_in)
  );

  // Clock; short pulses are counted, not polled
  initial clk_sys_in = 1'b0;
  always #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in)
  begin
    n_dl += int'(dl_start_out === 1'b1);
    n_ok += int'(report_ok_out === 1'b1);
    n_fail += int'(report_fail_out === 1'b1);
  end

  task automatic stop_test();
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Wait first, so valid never falls and rises in one step
  task automatic cmd(input logic [2:0] op, input logic [23:0] arg, input logic given);
    int k;
    k = 0;
    do @(negedge clk_sys_in); while (req_ready_out !== 1'b1 && ++k < 400);
    req_in = '{1'b1, ubch_pkg::ubch_cmd_t'(op), arg, given};
    @(negedge clk_sys_in);
    req_in.valid = 1'b0;
    rsp_q = '0;
    for (k = 0; k < 4 && rsp_q.valid !== 1'b1; k++)
      if (rsp_out.valid === 1'b1) rsp_q = rsp_out; else @(negedge clk_sys_in);
  endtask

  task automatic expect_st(input logic [2:0] op, input logic [23:0] arg, input logic [2:0] st);
    cmd(op, arg, 1'b1);
    check("status", rsp_q.status, st);
  endtask

  task automatic query(input logic [2:0] code, input logic det);
    cmd(3'h0, 24'h0, 1'b0);
    check("state code", rsp_q.code, code);
    check("detail flag", rsp_q.has_detail, det);
  endtask

  task automatic pop_ev(input logic [2:0] ev);
    check("event pin", ev_pin_out, 1'b1);
    check("event code", ev_code_out, ev);
    ev_pop_in = 1'b1;
    @(negedge clk_sys_in);
    ev_pop_in = 1'b0;
    @(negedge clk_sys_in);
  endtask

  task automatic pulse_done();
    dl_done_in = 1'b1;
    @(negedge clk_sys_in);
    dl_done_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
  endtask

  // One read: count, bytes in order through stalls, checksum, pointer
  task automatic do_read(input logic [23:0] n, input logic [23:0] exp_n);
    logic [15:0] sum;
    logic [23:0] start;
    int          k;
    sum = 16'h0000;
    start = ptr;
    cmd(3'h2, n, 1'b1);
    check("read status", rsp_q.status, 3'h0);
    check("read count", rsp_q.value, exp_n);
    for (k = 0; k < 200 && exp_n != 24'h0; k++)
    begin
      if (rd_valid_out === 1'b1 && rd_ready_in === 1'b1)
      begin
        check("last flag", rd_last_out, ptr - start == exp_n - 24'h1);
        check("read byte", rd_data_out, ptr[7:0] ^ 8'ha5);
        sum += {8'h00, ptr[7:0] ^ 8'ha5};
        ptr += 24'h1;
        if (rd_last_out === 1'b1) k = 200;
      end
      @(negedge clk_sys_in);
    end
    check("stream length", ptr - start, exp_n);
    check("stream idle", rd_valid_out, 1'b0);
    if (exp_n != 24'h0) check("checksum", rd_csum_out, sum);
    check("pointer", buf_addr_out, ptr);
  endtask

  // Nothing staged: buffer commands are refused
  task automatic t_idle();
    query(3'h0, 1'b0);
    check("pointer start", buf_addr_out, 24'h0);
    expect_st(3'h1, 24'h0, 3'h3);
    expect_st(3'h2, 24'h4, 3'h1);
    expect_st(3'h3, 24'h0, 3'h1);
    expect_st(3'h4, 24'h0, 3'h1);
  endtask

  // Host payload offered, accepted, downloaded; a second offer is turned away
  task automatic t_host_offer();
    int d;
    d = n_dl;
    prop_host_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    pop_ev(ubch_pkg::UBCH_EV_REQUEST);
    query(3'h2, 1'b1);
    check("meta detail", detail_is_meta_out, 1'b1);
    expect_st(3'h1, 24'h0, 3'h0);
    prop_host_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    check("download start", n_dl - d, 1);
    query(3'h3, 1'b0);
    expect_st(3'h2, 24'h1, 3'h1);
    pulse_done();
    query(3'h5, 1'b1);
    check("size detail", rsp_q.value, SIZE);
    pop_ev(ubch_pkg::UBCH_EV_HOST_READY);
    prop_host_in = 1'b1;
    @(negedge clk_sys_in);
    check("offer refused", prop_nack_out, 1'b1);
    prop_host_in = 1'b0;
  endtask

  // Chunks with clipping and end of payload, seeks, then close
  task automatic t_host_read();
    int o;
    ptr = 24'h0;
    do_read(24'd2, 24'd2);
    do_read(24'd20, 24'(MAXR));
    do_read(24'd9, 24'd6);
    do_read(24'd3, 24'd0);
    expect_st(3'h3, SIZE + 24'h1, 3'h2);
    check("pointer kept", buf_addr_out, SIZE);
    expect_st(3'h3, SIZE, 3'h0);
    cmd(3'h3, 24'd5, 1'b1);
    check("seek echo", rsp_q.value, 24'd5);
    ptr = 24'd5;
    do_read(24'd1, 24'd1);
    cmd(3'h3, 24'd9, 1'b0);
    check("seek home", rsp_q.value, 24'h0);
    check("pointer home", buf_addr_out, 24'h0);
    expect_st(3'h4, 24'h0, 3'h1);
    o = n_ok;
    expect_st(3'h5, 24'h0, 3'h0);
    repeat (2) @(negedge clk_sys_in);
    check("success report", n_ok - o, 1);
    query(3'h0, 1'b0);
  endtask

  // Module image: refusals, a good apply, boot, then a late upstream failure
  task automatic t_module();
    prop_mod_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    query(3'h1, 1'b1);
    check("version detail", detail_is_version_out, 1'b1);
    expect_st(3'h1, 24'h0, 3'h0);
    prop_mod_in = 1'b0;
    pulse_done();
    query(3'h4, 1'b0);
    expect_st(3'h4, 24'h0, 3'h4);
    sig_ok_in = 1'b1;
    expect_st(3'h4, 24'h0, 3'h3);
    img_ok_in = 1'b1;
    expect_st(3'h4, 24'h0, 3'h0);
    query(3'h0, 1'b0);
    pop_ev(ubch_pkg::UBCH_EV_BOOT_DONE);
    check("queue emptied", ev_pin_out, 1'b0);
    {sig_ok_in, img_ok_in, report_err_in} = 3'b001;
    @(negedge clk_sys_in);
    report_err_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    pop_ev(ubch_pkg::UBCH_EV_LINK_FAIL);
  endtask

  // Flush cuts a download short and reports failure
  task automatic t_flush();
    int f;
    f = n_fail;
    prop_mod_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    expect_st(3'h1, 24'h0, 3'h0);
    prop_mod_in = 1'b0;
    expect_st(3'h6, 24'h0, 3'h0);
    repeat (2) @(negedge clk_sys_in);
    check("failure report", n_fail - f, 1);
    query(3'h0, 1'b0);
    expect_st(3'h2, 24'h1, 3'h1);
  endtask

  // Main sequence
  initial
  begin
    resetn_in = 1'b0;
    req_in = '0;
    {prop_mod_in, prop_host_in, dl_done_in, sig_ok_in, img_ok_in} = 5'h00;
    {report_err_in, ev_pop_in} = 2'h0;
    img_size_in = SIZE;
    repeat (6) @(negedge clk_sys_in);
    resetn_in = 1'b1;
    t_idle();
    t_host_offer();
    t_host_read();
    t_module();
    t_flush();
    stop_test();
  end

  // Watchdog well past the scenarios' length
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    num_errors++;
    stop_test();
  end
endmodule
